// *** core/fsbe_engine.sv ***
// burst engine with one flow state per waveform
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// R1: one flow state, any of S0..S6; the sequencer reaches only S0..S1 writing and S0..S3 reading
// R2: flow ready logic separate from decision logic
// R3: only decision logic leaves the flow state
// R4: flow state drives control values from flow registers
// R5: lines held asserted, one word per clock
// R6: controller picks read and write waveform slots
// R7: internal ready 5 is count expired flag
// R8: write: S0 idle activity, S1 flow state
// R9: combine function and term source select flag
// R10: strobe select field picks control line
// R11: hold write data after the strobe
// R12: both edges selected move word per edge
// R13: strobe toggles with programmable half period
// R14: flag select chooses empty or full flag
// R15: flow condition follows selected fifo flag
// R16: flow state register: enable plus state number
// R17: write: zero flows data, one holds line
// R18: read: S0 idle, S1 S2 porch, S3 flow
// R19: read flow register enables state three
// R20: read: zero drives lines 1 2 low
// R21: firmware reloads flow setup before each launch
// R22: line 4 usable as strobe without pin
// R23: count drops per push or pop, zero ends
// R24: trigger bit 7 high when idle or done
// R25: trigger direction bit picks read or write
// R26: endpoint field selects one of four endpoints
// R27: leaving flow restores idle lines same cycle
// R28: stalled flow moves no data nor count
module fsbe_engine (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // endpoint buffers
  input wire logic [3:0] ep_empty_i,
  input wire logic [3:0] ep_full_i,
  input wire logic [15:0] ep_rd_data_i,
  output logic [1:0] ep_sel_o,
  output logic ep_pop_o,
  output logic ep_push_o,
  output logic [15:0] ep_wr_data_o,
  // peripheral pins
  input wire logic [15:0] pd_i,
  output logic [15:0] pd_o,
  output logic pd_oe_o,
  input wire logic [4:0] rdy_i,
  output logic [5:0] ctl_o,
  output logic [2:0] state_o
);
  `include "fsbe_consts.svh"

  fsbe_pkg::fsbe_eng_t r_q;
  fsbe_pkg::fsbe_eng_t r_d;
  logic fsm_en;
  logic [2:0] fsm_num;
  logic in_flow;
  logic cexp;
  logic fifo_flag;
  logic term_a;
  logic term_b;
  logic flow_cond;
  logic stb;
  logic tick;
  logic xfer;
  logic trig_wr;
  logic [2:0] last_st;
  logic [7:0] ctl_base;
  logic [7:0] ctl_mix;

  // ==========================================================
  // term source: ready pins, count expired, fifo flag, else zero
  function automatic logic term_val(input logic [2:0] src,
                                    input logic [4:0] rdy,
                                    input logic ce,
                                    input logic ff);
    logic v;
    v = 1'b0;
    if (src == `FSBE_TERM_FIFO)
      v = ff;
    else if (src == `FSBE_TERM_CEXP)
      v = ce;
    else if (src < `FSBE_TERM_CEXP)
      v = rdy[src];
    return v;
  endfunction

  // flag of endpoint ep chosen by its flag select code
  function automatic logic flag_of(input logic [1:0] code,
                                   input logic emp,
                                   input logic ful);
    logic v;
    v = 1'b0;
    if (code == `FSBE_FLG_EMPTY)
      v = emp;
    else if (code == `FSBE_FLG_FULL)
      v = ful;
    return v;
  endfunction

  // ==========================================================
  // flow state decode and flow condition
  assign fsm_en = r_q.fss[`FSBE_FSS_EN]; // R16 R19
  assign fsm_num = r_q.fss[2:0]; // R16
  // one flow state: only the numbered non-idle state flows
  assign in_flow = fsm_en && r_q.st != fsbe_pkg::ST_IDLE
                   && r_q.st == fsbe_pkg::fsbe_state_t'(fsm_num); // R1
  assign cexp = r_q.count == 16'h0000; // R7 R23
  assign fifo_flag = flag_of(r_q.flgsel[r_q.ep], ep_empty_i[r_q.ep],
                             ep_full_i[r_q.ep]); // R14
  // flow terms use their own sources, apart from the decision
  assign term_a = term_val(r_q.flog[5:3], r_q.rdy_sync, cexp,
                           fifo_flag); // R2 R9
  assign term_b = term_val(r_q.flog[2:0], r_q.rdy_sync, cexp,
                           fifo_flag); // R2 R9

  // combine function
  always_comb
  begin
    case (r_q.flog[7:6])
      `FSBE_FUNC_AND: flow_cond = term_a && term_b; // R9 R15
      `FSBE_FUNC_OR: flow_cond = term_a || term_b;
      `FSBE_FUNC_XOR: flow_cond = term_a ^ term_b;
      default: flow_cond = term_a && !term_b;
    endcase
  end

  // ==========================================================
  // strobe generator, running only inside the flow state
  fsbe_strobe_gen u_stb (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(in_flow),
    .half_i(r_q.half),
    .edge_sel_i(r_q.edge_sel),
    .strobe_o(stb),
    .tick_o(tick)
  );

  // a word moves on a strobe tick while flowing and count remains
  assign xfer = in_flow && tick && !flow_cond && !cexp; // R5 R28
  assign trig_wr = reg_wr_i && reg_addr_i == `FSBE_A_TRIG;
  assign last_st = r_q.dir ? `FSBE_RD_LAST : `FSBE_WR_LAST; // R8 R18

  // ==========================================================
  // control lines: idle values, or eq0 or eq1 in the flow state, plus strobe
  always_comb
  begin
    if (in_flow)
      ctl_base = flow_cond ? r_q.eq1 : r_q.eq0; // R4 R17 R20
    else
      ctl_base = r_q.idle_ctl; // R27
    ctl_mix = ctl_base;
    // any line, pinless line 4 too, may carry the strobe
    if (in_flow && r_q.fstb[2:0] < 3'(`FSBE_NCTL))
      ctl_mix[r_q.fstb[2:0]] = stb; // R10 R22
  end

  assign ctl_o = ctl_mix[5:0];

  // ==========================================================
  // next state: sequencer, registers, data path
  always_comb
  begin
    r_d = r_q;
    // pin synchronisers
    r_d.pd_meta = pd_i;
    r_d.pd_sync = r_q.pd_meta;
    r_d.rdy_meta = rdy_i;
    r_d.rdy_sync = r_q.rdy_meta;

    // decision-point sequencing
    case (r_q.st)
      fsbe_pkg::ST_IDLE:
      begin
        if (trig_wr)
        begin
          r_d.dir = reg_wdata_i[`FSBE_TRIG_RD]; // R25
          r_d.ep = reg_wdata_i[1:0]; // R26
          r_d.st = fsbe_pkg::ST_S0; // R8 R18
        end
      end
      default:
      begin
        if (in_flow)
        begin
          // only count expiry ends the flow state
          if (cexp)
            r_d.st = fsbe_pkg::ST_IDLE; // R3 R7
        end
        else if (3'(r_q.st) >= last_st)
          r_d.st = fsbe_pkg::ST_IDLE;
        else
          r_d.st = fsbe_pkg::fsbe_state_t'(3'(r_q.st) + 3'h1); // R18
      end
    endcase

    // one word per tick
    if (xfer)
      r_d.count = r_q.count - 16'h0001; // R23
    // a read word reaches pd_sync three edges after its strobe
    r_d.rd_pipe = {r_q.rd_pipe[1:0], xfer && r_q.dir};
    r_d.push = r_q.rd_pipe[2]; // R20
    if (r_q.rd_pipe[2])
      r_d.push_data = r_q.pd_sync;
    if (xfer && !r_q.dir)
    begin
      r_d.pd_out = ep_rd_data_i; // R17
      r_d.pd_oe = 1'b1;
      r_d.hold_cnt = r_q.hold;
    end
    else if (r_q.hold_cnt != 2'h0)
      r_d.hold_cnt = r_q.hold_cnt - 2'h1; // R11
    else
      r_d.pd_oe = 1'b0;

    // register writes
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `FSBE_A_FSS: r_d.fss = reg_wdata_i; // R21
        `FSBE_A_FLOG: r_d.flog = reg_wdata_i;
        `FSBE_A_EQ0: r_d.eq0 = reg_wdata_i;
        `FSBE_A_EQ1: r_d.eq1 = reg_wdata_i;
        `FSBE_A_FSTB: r_d.fstb = reg_wdata_i;
        `FSBE_A_HOLD: r_d.hold = reg_wdata_i[1:0];
        `FSBE_A_EDGE: r_d.edge_sel = reg_wdata_i[1:0];
        `FSBE_A_HALF: r_d.half = reg_wdata_i;
        `FSBE_A_IDLE: r_d.idle_ctl = reg_wdata_i;
        `FSBE_A_CNTL:
          if (r_q.st == fsbe_pkg::ST_IDLE)
            r_d.count[7:0] = reg_wdata_i;
        `FSBE_A_CNTH:
          if (r_q.st == fsbe_pkg::ST_IDLE)
            r_d.count[15:8] = reg_wdata_i;
        default:
          if (reg_addr_i >= `FSBE_A_FLG0 && reg_addr_i <= `FSBE_A_FLG3)
            r_d.flgsel[2'(reg_addr_i - `FSBE_A_FLG0)] =
              reg_wdata_i[1:0]; // R14
      endcase
    end

    // read data, valid the cycle after the read strobe
    r_d.rdata = `FSBE_RST_BYTE;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `FSBE_A_TRIG:
          r_d.rdata = {r_q.st == fsbe_pkg::ST_IDLE, 4'h0, r_q.dir,
                       r_q.ep}; // R24
        `FSBE_A_FSS: r_d.rdata = r_q.fss;
        `FSBE_A_FLOG: r_d.rdata = r_q.flog;
        `FSBE_A_EQ0: r_d.rdata = r_q.eq0;
        `FSBE_A_EQ1: r_d.rdata = r_q.eq1;
        `FSBE_A_FSTB: r_d.rdata = r_q.fstb;
        `FSBE_A_HOLD: r_d.rdata = {6'h00, r_q.hold};
        `FSBE_A_EDGE: r_d.rdata = {6'h00, r_q.edge_sel};
        `FSBE_A_HALF: r_d.rdata = r_q.half;
        `FSBE_A_IDLE: r_d.rdata = r_q.idle_ctl;
        `FSBE_A_CNTL: r_d.rdata = r_q.count[7:0];
        `FSBE_A_CNTH: r_d.rdata = r_q.count[15:8];
        default:
          r_d.rdata = {6'h00,
                       r_q.flgsel[2'(reg_addr_i - `FSBE_A_FLG0)]};
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      r_q <= '0;
      r_q.st <= fsbe_pkg::ST_IDLE;
      r_q.idle_ctl <= `FSBE_RST_CTL;
      r_q.eq1 <= `FSBE_RST_CTL;
      r_q.edge_sel <= `FSBE_RST_EDGE;
      r_q.half <= 8'(`FSBE_HALF_CYC);
      r_q.hold <= 2'(`FSBE_HOLD_CYC);
    end
    else
      r_q <= r_d;
  end

  // outputs
  assign reg_rdata_o = r_q.rdata;
  assign ep_sel_o = r_q.ep;
  assign ep_pop_o = xfer && !r_q.dir; // R17 R23
  assign ep_push_o = r_q.push; // R20 R23
  assign ep_wr_data_o = r_q.push_data;
  assign pd_o = r_q.pd_out;
  assign pd_oe_o = r_q.pd_oe;
  assign state_o = 3'(r_q.st);

  // ==========================================================
  // checks
  a_flow_exit_idle: assert property ( // R3
    @(posedge clk_i) disable iff (sys_rst_i)
    in_flow && cexp |=> r_q.st == fsbe_pkg::ST_IDLE && ctl_o ==
      r_q.idle_ctl[5:0])
    else $error("flow state not left at count expiry");
  a_flow_stays: assert property ( // R7
    @(posedge clk_i) disable iff (sys_rst_i)
    in_flow && !cexp |=> r_q.st == $past(r_q.st))
    else $error("flow state left before count expiry");
  a_count_step: assert property ( // R23
    @(posedge clk_i) disable iff (sys_rst_i)
    ep_pop_o || (xfer && r_q.dir)
    |=> r_q.count == $past(r_q.count) - 16'h0001)
    else $error("count did not drop by one per word");
  a_stall_no_move: assert property ( // R28
    @(posedge clk_i) disable iff (sys_rst_i)
    in_flow && flow_cond |-> !ep_pop_o ##4 !ep_push_o)
    else $error("data moved while flow stalled");
  a_write_drive: assert property ( // R17
    @(posedge clk_i) disable iff (sys_rst_i)
    ep_pop_o |=> pd_oe_o && pd_o == $past(ep_rd_data_i))
    else $error("write word not driven after pop");
  a_flow_ctl_vals: assert property ( // R4
    @(posedge clk_i) disable iff (sys_rst_i)
    in_flow && r_q.fstb[2:0] > 3'h2
    |-> ctl_o[2:0] == (flow_cond ? r_q.eq1[2:0] : r_q.eq0[2:0]))
    else $error("flow control values not applied");
  a_launch_dir: assert property ( // R25
    @(posedge clk_i) disable iff (sys_rst_i)
    trig_wr && r_q.st == fsbe_pkg::ST_IDLE
    |=> r_q.st == fsbe_pkg::ST_S0
      && r_q.dir == $past(reg_wdata_i[`FSBE_TRIG_RD]))
    else $error("trigger did not launch in its direction");
  a_done_bit: assert property ( // R24
    @(posedge clk_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == `FSBE_A_TRIG
    |=> reg_rdata_o[7] == ($past(r_q.st) == fsbe_pkg::ST_IDLE))
    else $error("done bit does not show idle");
  a_read_porch: assert property ( // R18
    @(posedge clk_i) disable iff (sys_rst_i)
    r_q.st == fsbe_pkg::ST_S0 && r_q.dir && r_q.fss == 8'h83
    |=> r_q.st == fsbe_pkg::ST_S1 ##1 r_q.st == fsbe_pkg::ST_S2
    ##1 r_q.st == fsbe_pkg::ST_S3)
    else $error("read porch sequence broken");
endmodule

// *** core/fsbe_consts.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef FSBE_CONSTS_SVH
`define FSBE_CONSTS_SVH

// ==========================================================
// register offsets on the plain register port
`define FSBE_A_TRIG 4'h0
`define FSBE_A_FSS 4'h1
`define FSBE_A_FLOG 4'h2
`define FSBE_A_EQ0 4'h3
`define FSBE_A_EQ1 4'h4
`define FSBE_A_FSTB 4'h5
`define FSBE_A_HOLD 4'h6
`define FSBE_A_EDGE 4'h7
`define FSBE_A_HALF 4'h8
`define FSBE_A_FLG0 4'h9
`define FSBE_A_FLG3 4'hc
`define FSBE_A_CNTL 4'hd
`define FSBE_A_CNTH 4'he
`define FSBE_A_IDLE 4'hf

// ==========================================================
// field positions
`define FSBE_TRIG_DONE 7
`define FSBE_TRIG_RD 2
`define FSBE_FSS_EN 7
`define FSBE_EDGE_RISE 0
`define FSBE_EDGE_FALL 1

// ==========================================================
// codes
`define FSBE_FUNC_AND 2'h0
`define FSBE_FUNC_OR 2'h1
`define FSBE_FUNC_XOR 2'h2
`define FSBE_TERM_CEXP 3'h5
`define FSBE_TERM_FIFO 3'h6
`define FSBE_FLG_EMPTY 2'h1
`define FSBE_FLG_FULL 2'h2
`define FSBE_WR_LAST 3'h1
`define FSBE_RD_LAST 3'h3
`define FSBE_NCTL 6

// ==========================================================
// reset values
`define FSBE_RST_BYTE 8'h00
`define FSBE_RST_EDGE 2'h3
`define FSBE_RST_CTL 8'h3f

// ==========================================================
// timing: clock period, strobe half period and data hold, in ps
`define FSBE_CLK_PS 40000
`define FSBE_HALF_PS 20830
`define FSBE_HOLD_PS 10000
`define FSBE_HALF_CYC ((`FSBE_HALF_PS + `FSBE_CLK_PS - 1) / `FSBE_CLK_PS)
`define FSBE_HOLD_CYC ((`FSBE_HOLD_PS + `FSBE_CLK_PS - 1) / `FSBE_CLK_PS)

`endif

// *** core/fsbe_pkg.sv ***
// types shared by the burst engine and its strobe generator
package fsbe_pkg;

  // waveform states; the index of S0..S6 is the state number
  typedef enum logic [2:0] {
    ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6, ST_IDLE
  } fsbe_state_t;

  // strobe generator state
  typedef struct packed {
    logic [7:0] cnt;
    logic level;
  } fsbe_stb_t;

  // engine state
  typedef struct packed {
    fsbe_state_t st;
    logic dir;
    logic [1:0] ep;
    logic [15:0] count;
    logic [7:0] fss;
    logic [7:0] flog;
    logic [7:0] eq0;
    logic [7:0] eq1;
    logic [7:0] fstb;
    logic [7:0] idle_ctl;
    logic [7:0] half;
    logic [1:0] hold;
    logic [1:0] edge_sel;
    logic [3:0][1:0] flgsel;
    logic [15:0] pd_meta;
    logic [15:0] pd_sync;
    logic [4:0] rdy_meta;
    logic [4:0] rdy_sync;
    logic [15:0] pd_out;
    logic pd_oe;
    logic [1:0] hold_cnt;
    logic [2:0] rd_pipe;
    logic push;
    logic [15:0] push_data;
    logic [7:0] rdata;
  } fsbe_eng_t;

endpackage

// *** core/fsbe_strobe_gen.sv ***
// flow strobe toggler with per-edge transfer ticks
`timescale 1ns/1ps
module fsbe_strobe_gen (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic run_i,
  input wire logic [7:0] half_i,
  input wire logic [1:0] edge_sel_i,
  // strobe and tick
  output logic strobe_o,
  output logic tick_o
);
  `include "fsbe_consts.svh"

  fsbe_pkg::fsbe_stb_t s_q;
  fsbe_pkg::fsbe_stb_t s_d;
  logic flip;

  // ==========================================================
  // half period counter; strobe parks low when not running
  always_comb
  begin
    s_d = s_q;
    flip = run_i && (s_q.cnt + 8'h01 >= half_i);
    tick_o = 1'b0;
    if (!run_i)
    begin
      s_d.cnt = 8'h00;
      s_d.level = 1'b0;
    end
    else if (flip)
    begin
      s_d.cnt = 8'h00;
      s_d.level = !s_q.level; // R13
      // a rising or falling edge moves one word when its edge_sel bit is set
      tick_o = s_q.level ? edge_sel_i[`FSBE_EDGE_FALL]
                         : edge_sel_i[`FSBE_EDGE_RISE]; // R12
    end
    else
    begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign strobe_o = s_q.level;

  // ==========================================================
  // checks
  a_both_edges_tick: assert property ( // R12
    @(posedge clk_i) disable iff (sys_rst_i)
    run_i && $past(run_i) && half_i == 8'h01 && edge_sel_i == 2'h3
    |-> tick_o && (strobe_o != $past(strobe_o)))
    else $error("strobe did not move a word on every edge");
  a_strobe_parks: assert property ( // R13
    @(posedge clk_i) disable iff (sys_rst_i)
    !run_i |-> !tick_o ##1 !strobe_o)
    else $error("strobe kept toggling while stopped");
endmodule

// *** tb/fsbe_ext_fifo.sv ***
// model of the external synchronous fifo on the peripheral pins
`timescale 1ns/1ps
module fsbe_ext_fifo (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // pins
  input wire logic [5:0] ctl_i,
  output logic [15:0] pd_o
);
  logic [7:0] k_q;
  // a word leaves on each rising clock edge while read and output enable are low
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      k_q <= 8'h00;
      pd_o <= 16'h0000;
    end
    else if (ctl_i[1] == 1'b0 && ctl_i[2] == 1'b0)
    begin
      k_q <= k_q + 8'h01;
      pd_o <= {8'hb5, k_q};
    end
    else
      pd_o <= ~pd_o; // released bus: alternates between the last word and its inverse
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the flow state burst engine
`timescale 1ns/1ps
`include "fsbe_consts.svh"
`define CHK(n, e, g) \
  begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] r;
    logic [7:0] w;
  } fsbe_row_t;
  // ==========================================================
  // signals
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [3:0] ep_empty_i = 4'h0;
  logic [3:0] ep_full_i = 4'h0;
  logic [15:0] ep_rd_data_i;
  logic [1:0] ep_sel_o;
  logic ep_pop_o;
  logic ep_push_o;
  logic pd_oe_o;
  logic [15:0] ep_wr_data_o;
  logic [15:0] pd_o;
  logic [15:0] pd_i;
  logic [15:0] ext_pd;
  logic [4:0] rdy_i = 5'h00;
  logic [5:0] ctl_o;
  logic [2:0] state_o;
  int error_cnt = 0;
  int compares = 0;
  int pop_cnt = 0;
  int push_cnt = 0;
  int i;
  int n;
  int k;
  logic [15:0] exp_w;
  logic [7:0] rd_v;
  logic pend = 1'b0;
  logic wmode = 1'b1;
  logic chk_on = 1'b0;
  logic stl;
  logic [2:0] flow_st = 3'h1;
  logic [2:0] prev_st = 3'h7;
  logic prev_stl = 1'b1;
  logic prev_c4 = 1'b0;
  fsbe_row_t rows [13] = '{
    '{`FSBE_A_FSS, 8'h00, 8'h81}, '{`FSBE_A_FLOG, 8'h00, 8'h36},
    '{`FSBE_A_EQ0, 8'h00, 8'h3e}, '{`FSBE_A_EQ1, 8'h3f, 8'h3f},
    '{`FSBE_A_FSTB, 8'h00, 8'h04}, '{`FSBE_A_HOLD, 8'h01, 8'h01},
    '{`FSBE_A_EDGE, 8'h03, 8'h03}, '{`FSBE_A_HALF, 8'h01, 8'h01},
    '{`FSBE_A_FLG0, 8'h00, 8'h01}, '{4'hb, 8'h00, 8'h02},
    '{`FSBE_A_IDLE, 8'h3f, 8'h3f}, '{`FSBE_A_CNTH, 8'h00, 8'h00},
    '{`FSBE_A_CNTL, 8'h00, 8'h06}};

  // endpoint head word, far-side fifo and the shared data wire
  always @(posedge clk_i) ep_rd_data_i <= 16'ha000 + pop_cnt[15:0];
  assign pd_i = pd_oe_o ? pd_o : ext_pd;
  always #20 clk_i = ~clk_i;

  fsbe_engine uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ep_empty_i(ep_empty_i), .ep_full_i(ep_full_i),
    .ep_rd_data_i(ep_rd_data_i), .ep_sel_o(ep_sel_o),
    .ep_pop_o(ep_pop_o), .ep_push_o(ep_push_o),
    .ep_wr_data_o(ep_wr_data_o), .pd_i(pd_i), .pd_o(pd_o),
    .pd_oe_o(pd_oe_o), .rdy_i(rdy_i), .ctl_o(ctl_o), .state_o(state_o));
  fsbe_ext_fifo ext (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ctl_i(ctl_o), .pd_o(ext_pd));

  // mid-cycle monitor: data after pops, lines and strobe in flow
  always @(negedge clk_i)
  begin
    stl = wmode ? ep_empty_i[0] : ep_full_i[2];
    if (pend) `CHK("pd_o", exp_w, pd_o)
    if (pend) `CHK("pd_oe_o", 1'b1, pd_oe_o)
    if (chk_on && wmode && state_o === flow_st && !stl)
      `CHK("write_strobe_line flow", 1'b0, ctl_o[0])
    if (chk_on && !wmode && state_o === flow_st && !stl)
      `CHK("ctl12 flow", 2'b00, ctl_o[2:1])
    if (chk_on && wmode && stl) `CHK("pop stall", 1'b0, ep_pop_o)
    if (chk_on && state_o === flow_st && prev_st === flow_st && !stl &&
        !prev_stl)
      `CHK("internal_strobe_line", ~prev_c4, ctl_o[4])
    pend = ep_pop_o;
    if (ep_pop_o)
    begin
      exp_w = ep_rd_data_i;
      pop_cnt++;
    end
    if (ep_push_o)
    begin
      `CHK("push data", {8'hb5, push_cnt[7:0]}, ep_wr_data_o)
      push_cnt++;
    end
    prev_st = state_o;
    prev_stl = stl;
    prev_c4 = ctl_o[4];
  end

  // ==========================================================
  // register port and waits
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task summarize;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task timeout;
    error_cnt++;
    $display("Error wait exp done got hang");
    summarize;
  endtask

  task wait_st(input logic [2:0] s);
    #1;
    for (n = 0; n < 200 && state_o !== s; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    if (n == 200)
      timeout;
  endtask

  task wait_idle;
    wait_st(3'h7);
  endtask

  task wait_cnt(input logic sel, input int lim);
    for (n = 0; n < 200 && (sel ? push_cnt : pop_cnt) < lim; n++)
      @(posedge clk_i);
    if (n == 200)
      timeout;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`FSBE_A_TRIG, rd_v);
    `CHK("trig reset", 8'h80, rd_v)
    `CHK("ctl reset", 6'h3f, ctl_o)
    // reset value, write, read back for every row
    for (i = 0; i < 13; i++)
    begin
      rd(rows[i].a, rd_v);
      `CHK("reset value", rows[i].r, rd_v)
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rd_v);
      `CHK("read back", rows[i].w, rd_v)
    end
    // write burst of six words with a stall after three
    chk_on = 1'b1;
    wr(`FSBE_A_TRIG, 8'h00);
    wait_cnt(1'b0, 2);
    @(posedge clk_i);
    ep_empty_i <= 4'h1;
    repeat (2) @(posedge clk_i);
    k = pop_cnt;
    repeat (4) @(posedge clk_i);
    #1 `CHK("stall pops", k, pop_cnt)
    `CHK("stall write_strobe_line", 1'b1, ctl_o[0])
    `CHK("stall state", 3'h1, state_o)
    @(posedge clk_i);
    ep_empty_i <= 4'h0;
    wait_idle;
    `CHK("pops", 6, pop_cnt)
    `CHK("idle ctl", 6'h3f, ctl_o)
    `CHK("hold oe", 1'b1, pd_oe_o)
    @(posedge clk_i);
    #1 `CHK("oe off", 1'b0, pd_oe_o)
    rd(`FSBE_A_CNTL, rd_v);
    `CHK("count end", 8'h00, rd_v)
    rd(`FSBE_A_TRIG, rd_v);
    `CHK("trig done", 8'h80, rd_v)
    // read burst of five words into endpoint code 2
    wmode = 1'b0;
    flow_st = 3'h3;
    wr(`FSBE_A_FSS, 8'h83);
    wr(`FSBE_A_EQ0, 8'h39);
    wr(`FSBE_A_CNTL, 8'h05);
    wr(`FSBE_A_TRIG, 8'h06);
    wait_st(3'h3);
    `CHK("ep sel rd", 2'h2, ep_sel_o)
    @(posedge clk_i);
    ep_full_i <= 4'h4;
    repeat (4) @(posedge clk_i);
    k = push_cnt;
    repeat (4) @(posedge clk_i);
    #1 `CHK("stall push", k, push_cnt)
    `CHK("stall ctl12", 2'b11, ctl_o[2:1])
    `CHK("read flow st", 3'h3, state_o)
    @(posedge clk_i);
    ep_full_i <= 4'h0;
    wait_idle;
    wait_cnt(1'b1, 5);
    `CHK("pushes", 5, push_cnt)
    `CHK("idle ctl rd", 6'h3f, ctl_o)
    // launches without flow on every endpoint code, both directions
    chk_on = 1'b0;
    wr(`FSBE_A_FSS, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      k = pop_cnt + push_cnt;
      wr(`FSBE_A_TRIG, {5'h00, i[0], i[1:0]});
      @(posedge clk_i);
      #1 `CHK("ep sel", i[1:0], ep_sel_o)
      wait_idle;
      rd(`FSBE_A_TRIG, rd_v);
      `CHK("trig idle", {5'h10, i[0], i[1:0]}, rd_v)
      `CHK("no flow data", k, pop_cnt + push_cnt)
    end
    summarize;
  end
endmodule
